// ---- common/lte_pkg.sv ----
/*
 Package for the lookup table entry access block: table geometry, word
 mapping of the entry into the three word registers, entry field layout
 and type codes. Assumes a 5-port or 9-port switch build.
*/
package lte_pkg;
   // Number of switch ports (5 or 9) and the resulting entry width.
   localparam int unsigned LTE_NPORTS      = 5;
   localparam int unsigned LTE_ENTRY_W     = 66 + LTE_NPORTS;
   // Table depth and pointer width.
   localparam int unsigned LTE_DEPTH       = 64;
   localparam int unsigned LTE_PTR_W       = 6;
   localparam int unsigned LTE_WORD_W      = 32;
   localparam int unsigned LTE_W2_W        = LTE_ENTRY_W - 2 * LTE_WORD_W;
   localparam int unsigned LTE_W0_LSB      = 0;
   localparam int unsigned LTE_W1_LSB      = 32;
   localparam int unsigned LTE_W2_LSB      = 64;
   // Entry field positions.
   localparam int unsigned LTE_TYPE_LSB    = 60;
   localparam int unsigned LTE_UCLASS_LSB  = 62;
   localparam int unsigned LTE_SECURE_BIT  = 64;
   localparam int unsigned LTE_SUPER_BIT   = 65;
   localparam int unsigned LTE_MASK_LSB    = 66;
   localparam int unsigned LTE_VID_LSB     = 48;
   localparam int unsigned LTE_GROUP_BIT   = 40;
   localparam int unsigned LTE_OUI_LSB     = 24;
   localparam int unsigned LTE_KFLOOD_LSB  = 44;
   localparam int unsigned LTE_UFLOOD_LSB  = 20;
   localparam int unsigned LTE_UNTAG_LSB   = 24;
   localparam int unsigned LTE_ICHK_BIT    = 65;
   // Entry type codes.
   localparam logic [1:0]  LTE_TYPE_FREE   = 2'h0;
   localparam logic [1:0]  LTE_TYPE_ADDR   = 2'h1;
   localparam logic [1:0]  LTE_TYPE_VLAN   = 2'h2;
   localparam logic [1:0]  LTE_TYPE_VADDR  = 2'h3;
   // Unicast class codes.
   localparam logic [1:0]  LTE_UC_FIXED    = 2'h0;
   localparam logic [1:0]  LTE_UC_AGE_NEW  = 2'h1;
   localparam logic [1:0]  LTE_UC_OUI      = 2'h2;
   localparam logic [1:0]  LTE_UC_AGE_USED = 2'h3;
   localparam logic [LTE_PTR_W:0] LTE_DEPTH_VAL = 7'h40;
   localparam logic [LTE_ENTRY_W-1:0] LTE_ENTRY_RST = '0;
   // Decoded kind of an entry.
   typedef enum logic [6:0] {
      LTE_K_FREE   = 7'b000_0001,
      LTE_K_MCAST  = 7'b000_0010,
      LTE_K_VMCAST = 7'b000_0100,
      LTE_K_UCAST  = 7'b000_1000,
      LTE_K_OUI    = 7'b001_0000,
      LTE_K_VUCAST = 7'b010_0000,
      LTE_K_VLAN   = 7'b100_0000
   } lte_kind_t;
endpackage

// ---- design/lte_entry_decode.sv ----
/*
 Field decoder for one table entry: splits an entry into its kind and
 the fields of every layout. Purely combinational; assumes entry type
 codes as defined in the package.
*/
`timescale 1ns/100ps
module lte_entry_decode (
   // Entry under inspection.
   input  wire logic [lte_pkg::LTE_ENTRY_W-1:0]  entry,
   // Decoded kind and fields.
   output lte_pkg::lte_kind_t                    kind,
   output logic [47:0]                           mac_addr,
   output logic [11:0]                           vlan_tag_ident,
   output logic [1:0]                            group_forward_state,
   output logic [1:0]                            unicast_class,
   output logic                                  super_flag,
   output logic                                  secure_flag,
   output logic                                  block_flag,
   output logic [lte_pkg::LTE_NPORTS-1:0]        port_mask,
   output logic [lte_pkg::LTE_NPORTS-2:0]        egress_port,
   output logic [23:0]                           org_identifier,
   output logic [2:0]                            known_group_flood_sel,
   output logic [2:0]                            unknown_group_flood_sel,
   output logic [lte_pkg::LTE_NPORTS-1:0]        member_port_bits,
   output logic [lte_pkg::LTE_NPORTS-1:0]        untag_mask,
   output logic                                  member_ingress_check,
   output logic [lte_pkg::LTE_NPORTS-1:0]        no_learn_mask
);
   import lte_pkg::*;

   logic [1:0] etype;
   logic       is_group;

   // Field extraction shared by all layouts.
   assign etype                   = entry[LTE_TYPE_LSB +: 2];
   assign is_group                = entry[LTE_GROUP_BIT];
   assign mac_addr                = entry[47:0];
   assign vlan_tag_ident          = entry[LTE_VID_LSB +: 12];
   assign group_forward_state     = entry[LTE_UCLASS_LSB +: 2];
   assign unicast_class           = entry[LTE_UCLASS_LSB +: 2];
   assign super_flag              = entry[LTE_SUPER_BIT];
   assign block_flag              = entry[LTE_SUPER_BIT];
   assign secure_flag             = entry[LTE_SECURE_BIT];
   assign port_mask               = entry[LTE_MASK_LSB +: LTE_NPORTS];
   assign egress_port             = entry[LTE_MASK_LSB +: LTE_NPORTS-1];
   assign org_identifier          = entry[LTE_OUI_LSB +: 24];
   assign known_group_flood_sel   = entry[LTE_KFLOOD_LSB +: 3];
   assign unknown_group_flood_sel = entry[LTE_UFLOOD_LSB +: 3];
   assign member_port_bits        = entry[LTE_NPORTS-1:0];
   assign untag_mask              = entry[LTE_UNTAG_LSB +: LTE_NPORTS];
   assign member_ingress_check    = entry[LTE_ICHK_BIT];
   assign no_learn_mask           = entry[LTE_MASK_LSB +: LTE_NPORTS];

   // Kind decode from the type code, group bit and unicast class.
   always_comb begin
      kind = LTE_K_FREE;
      unique case (etype)
         LTE_TYPE_FREE: kind = LTE_K_FREE;
         LTE_TYPE_VLAN: kind = LTE_K_VLAN;
         LTE_TYPE_ADDR: begin
            if (is_group) begin
               kind = LTE_K_MCAST;
            end else if (unicast_class == LTE_UC_OUI) begin
               kind = LTE_K_OUI;
            end else begin
               kind = LTE_K_UCAST;
            end
         end
         LTE_TYPE_VADDR: begin
            kind = is_group ? LTE_K_VMCAST : LTE_K_VUCAST;
         end
      endcase
   end
endmodule

// ---- design/lte_table_access.sv ----
/*
 Indirect access to the address lookup table: three table word registers,
 a control strobe carrying a pointer and a direction, and flip-flop table
 storage. The fields held in the word registers are decoded for view.
 Assumes software strobes only on the switch core clock; no bus, plain ports.
*/
`timescale 1ns/100ps
module lte_table_access (
   // Clock and reset.
   input  wire logic                             clock,
   input  wire logic                             reset_n,
   // Table word register writes.
   input  wire logic [2:0]                       word_wr,
   input  wire logic [lte_pkg::LTE_WORD_W-1:0]   word_wdata,
   // Table access control write.
   input  wire logic                             table_access_control_wr,
   input  wire logic [lte_pkg::LTE_PTR_W-1:0]    entry_pointer,
   input  wire logic                             access_direction,
   // Table word register contents.
   output logic [lte_pkg::LTE_WORD_W-1:0]        table_word0,
   output logic [lte_pkg::LTE_WORD_W-1:0]        table_word1,
   output logic [lte_pkg::LTE_W2_W-1:0]          table_word2,
   // Status.
   output logic [lte_pkg::LTE_PTR_W:0]           table_depth,
   output logic                                  access_done,
   output logic [lte_pkg::LTE_PTR_W-1:0]         last_pointer,
   // Decoded view of the word registers.
   output lte_pkg::lte_kind_t                    word_kind,
   output logic [11:0]                           word_vlan_tag_ident,
   output logic [23:0]                           word_org_identifier,
   output logic                                  word_entry_free
);
   import lte_pkg::*;

   logic [LTE_ENTRY_W-1:0] table_q [LTE_DEPTH];
   logic [LTE_ENTRY_W-1:0] table_d [LTE_DEPTH];
   logic [LTE_ENTRY_W-1:0] words_q;
   logic [LTE_ENTRY_W-1:0] words_d;
   logic                   done_q;
   logic                   done_d;
   logic [LTE_PTR_W-1:0]   ptr_q;
   logic [LTE_PTR_W-1:0]   ptr_d;
   logic                   rd_go;
   logic                   wr_go;

   // Decoded strobes; a write commits the words as they stand that cycle.
   assign rd_go = table_access_control_wr && !access_direction;
   assign wr_go = table_access_control_wr && access_direction;

   // Table storage next values, one per entry.
   genvar gi;
   generate
      for (gi = 0; gi < LTE_DEPTH; gi++) begin : g_entry
         always_comb begin
            table_d[gi] = table_q[gi];
            if (wr_go && (entry_pointer == LTE_PTR_W'(gi))) begin
               table_d[gi] = words_q;
            end
         end
         always_ff @(posedge clock) begin
            if (!reset_n) begin
               table_q[gi] <= LTE_ENTRY_RST;
            end else begin
               table_q[gi] <= table_d[gi];
            end
         end
      end
   endgenerate

   // Word register and status next values; a table read outranks word writes.
   always_comb begin
      words_d = words_q;
      done_d  = 1'b0;
      ptr_d   = ptr_q;
      if (word_wr[0]) begin
         words_d[LTE_W0_LSB +: LTE_WORD_W] = word_wdata;
      end
      if (word_wr[1]) begin
         words_d[LTE_W1_LSB +: LTE_WORD_W] = word_wdata;
      end
      if (word_wr[2]) begin
         words_d[LTE_W2_LSB +: LTE_W2_W] = word_wdata[LTE_W2_W-1:0];
      end
      if (rd_go) begin
         words_d = table_q[entry_pointer];
      end
      if (table_access_control_wr) begin
         done_d = 1'b1;
         ptr_d  = entry_pointer;
      end
   end

   // Registers of the access side.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         words_q <= LTE_ENTRY_RST;
         done_q  <= 1'b0;
         ptr_q   <= '0;
      end else begin
         words_q <= words_d;
         done_q  <= done_d;
         ptr_q   <= ptr_d;
      end
   end

   // Outputs; word two holds the upper entry bits.
   assign table_word0     = words_q[LTE_W0_LSB +: LTE_WORD_W];
   assign table_word1     = words_q[LTE_W1_LSB +: LTE_WORD_W];
   assign table_word2     = words_q[LTE_W2_LSB +: LTE_W2_W];
   assign table_depth     = LTE_DEPTH_VAL;
   assign access_done     = done_q;
   assign last_pointer    = ptr_q;
   assign word_entry_free = (words_q[LTE_TYPE_LSB +: 2] == LTE_TYPE_FREE);

   // Layout decode of the word registers.
   lte_entry_decode u_decode (
      .entry                   (words_q),
      .kind                    (word_kind),
      .mac_addr                (),
      .vlan_tag_ident          (word_vlan_tag_ident),
      .group_forward_state     (),
      .unicast_class           (),
      .super_flag              (),
      .secure_flag             (),
      .block_flag              (),
      .port_mask               (),
      .egress_port             (),
      .org_identifier          (word_org_identifier),
      .known_group_flood_sel   (),
      .unknown_group_flood_sel (),
      .member_port_bits        (),
      .untag_mask              (),
      .member_ingress_check    (),
      .no_learn_mask           ()
   );

   // A read loads the addressed entry into the words on the next edge.
   AST_READ_LOADS: assert property (@(posedge clock) disable iff (!reset_n)
      rd_go && !wr_go |=> words_q == $past(table_q[entry_pointer]))
      else $error("word registers did not take the addressed entry");

   // A read leaves the addressed entry unchanged.
   AST_READ_KEEPS: assert property (@(posedge clock) disable iff (!reset_n)
      rd_go |=> table_q[$past(entry_pointer)] == $past(table_q[entry_pointer]))
      else $error("table changed on a read");

   // A write stores the word registers at the pointer.
   AST_WRITE_STORES: assert property (@(posedge clock) disable iff (!reset_n)
      wr_go |=> table_q[$past(entry_pointer)] == $past(words_q))
      else $error("table entry did not take the word registers");

   // A write leaves the word registers as software loaded them.
   AST_WRITE_KEEPS_WORDS: assert property (@(posedge clock) disable iff (!reset_n)
      wr_go && (word_wr == 3'h0) |=> words_q == $past(words_q))
      else $error("word registers changed on a table write");

   // Done pulses exactly one cycle after each control write.
   AST_DONE_PULSE: assert property (@(posedge clock) disable iff (!reset_n)
      table_access_control_wr |=> access_done ##1 (access_done == $past(table_access_control_wr)))
      else $error("done pulse wrong");

   // Done never rises unless a control write was taken on the edge before.
   AST_DONE_CAUSE: assert property (@(posedge clock) disable iff (!reset_n)
      access_done |-> $past(table_access_control_wr))
      else $error("done pulse without a control write");

   // Free words decode as a free entry.
   AST_FREE_KIND: assert property (@(posedge clock) disable iff (!reset_n)
      word_entry_free |-> word_kind == LTE_K_FREE)
      else $error("free entry decoded as used");

   // Word zero reflects a word zero write one cycle later.
   AST_WORD0_MAP: assert property (@(posedge clock) disable iff (!reset_n)
      word_wr[0] && !rd_go |=> table_word0 == $past(word_wdata))
      else $error("word zero mapping wrong");
endmodule

// ---- dv/lte_table_access_tb.sv ----
/*
 Self-checking testbench for the lookup table entry access block: loads the
 word registers, commits and reads back entries of every layout, and checks
 the decoded view, the done pulse and reset values.
 Assumes the package geometry of a 5-port switch and a 64-entry table.
*/
`timescale 1ns/100ps
module testbench;
   import lte_pkg::*;
   // Clock, reset and stimulus.
   logic                      clock;
   logic                      reset_n;
   logic [2:0]                word_wr;
   logic [LTE_WORD_W-1:0]     word_wdata;
   logic                      table_access_control_wr;
   logic [LTE_PTR_W-1:0]      entry_pointer;
   logic                      access_direction;
   // Observed outputs.
   logic [LTE_WORD_W-1:0]     table_word0;
   logic [LTE_WORD_W-1:0]     table_word1;
   logic [LTE_W2_W-1:0]       table_word2;
   logic [LTE_PTR_W:0]        table_depth;
   logic                      access_done;
   logic [LTE_PTR_W-1:0]      last_pointer;
   lte_kind_t                 word_kind;
   logic [11:0]               word_vlan_tag_ident;
   logic [23:0]               word_org_identifier;
   logic                      word_entry_free;
   int                        bad_count;
   int                        n_checks;
   logic [LTE_ENTRY_W-1:0]    ent;
   logic [LTE_PTR_W-1:0]      tgt;
   lte_kind_t                 kinds [9];

   lte_table_access DUT (
      .clock                   (clock),
      .reset_n                 (reset_n),
      .word_wr                 (word_wr),
      .word_wdata              (word_wdata),
      .table_access_control_wr (table_access_control_wr),
      .entry_pointer           (entry_pointer),
      .access_direction        (access_direction),
      .table_word0             (table_word0),
      .table_word1             (table_word1),
      .table_word2             (table_word2),
      .table_depth             (table_depth),
      .access_done             (access_done),
      .last_pointer            (last_pointer),
      .word_kind               (word_kind),
      .word_vlan_tag_ident     (word_vlan_tag_ident),
      .word_org_identifier     (word_org_identifier),
      .word_entry_free         (word_entry_free)
   );

   // Free-running 200 MHz clock.
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // Compares one value against its expectation and counts the outcome.
   task automatic check(input logic [70:0] seen, input logic [70:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Holds reset low for three cycles, driven at the falling edge.
   task automatic do_reset;
      reset_n = 1'b0;
      repeat (3) @(negedge clock);
      reset_n = 1'b1;
   endtask

   // Loads the three word registers back to back with one entry.
   task automatic load_entry(input logic [70:0] e);
      for (int i = 0; i < 3; i++) begin
         @(negedge clock);
         word_wr = 3'(1 << i);
         word_wdata = (i == 0) ? e[31:0] : (i == 1) ? e[63:32] : {25'h000_0000, e[70:64]};
      end
      @(negedge clock);
      word_wr = 3'h0;
   endtask

   // Issues one control pulse and checks the one-cycle done answer.
   task automatic ctl(input logic [5:0] p, input logic d);
      @(negedge clock);
      table_access_control_wr = 1'b1;
      entry_pointer = p;
      access_direction = d;
      @(negedge clock);
      table_access_control_wr = 1'b0;
      check(71'(access_done), 71'h1, "done pulse");
      check(71'(last_pointer), 71'(p), "last pointer");
      @(negedge clock);
      check(71'(access_done), 71'h0, "done falls");
   endtask

   // Compares the word registers and their decoded view with an entry.
   task automatic check_words(input logic [70:0] e, input lte_kind_t k);
      check({table_word2, table_word1, table_word0}, e, "words");
      check(71'(word_kind), 71'(k), "kind");
      check(71'(word_vlan_tag_ident), 71'(e[59:48]), "vlan tag");
      check(71'(word_org_identifier), 71'(e[47:24]), "org id");
      check(71'(word_entry_free), 71'(e[61:60] == 2'h0), "free flag");
   endtask

   // Main sequence.
   initial begin
      bad_count = 0;
      n_checks = 0;
      word_wr = 3'h0;
      word_wdata = '0;
      table_access_control_wr = 1'b0;
      entry_pointer = '0;
      access_direction = 1'b0;
      kinds = '{LTE_K_FREE, LTE_K_MCAST, LTE_K_VMCAST, LTE_K_UCAST, LTE_K_UCAST,
                LTE_K_UCAST, LTE_K_OUI, LTE_K_VUCAST, LTE_K_VLAN};
      do_reset();
      // Reset values and reported depth.
      check(71'(table_depth), 71'h0040, "depth");
      check_words('0, LTE_K_FREE);
      check(71'(access_done), 71'h0, "done idle");
      $display("test reset values done");
      // Every layout: check the target is free, load, decode, commit, clear words, read back.
      for (int i = 0; i < 9; i++) begin
         tgt = (i == 8) ? 6'h00 : 6'(63 - i);
         ent = 71'h2B_C3A5_96F0_0FED_CBA9;
         ent[61:60] = (i == 0) ? LTE_TYPE_FREE : (i == 2 || i == 7) ? LTE_TYPE_VADDR :
                      (i == 8) ? LTE_TYPE_VLAN : LTE_TYPE_ADDR;
         ent[63:62] = (i == 3) ? LTE_UC_FIXED : (i == 4 || i == 7) ? LTE_UC_AGE_NEW :
                      (i == 6) ? LTE_UC_OUI : (i == 8) ? 2'h0 : LTE_UC_AGE_USED;
         ent[40] = (i == 1 || i == 2);
         ctl(tgt, 1'b0);
         check(71'(word_entry_free), 71'h1, "target free");
         load_entry(ent);
         check_words(ent, kinds[i]);
         ctl(tgt, 1'b1);
         ctl(6'h20, 1'b0);
         check_words('0, LTE_K_FREE);
         ctl(tgt, 1'b0);
         check_words(ent, kinds[i]);
      end
      $display("test entry layouts done");
      // Word write beside a table write: the commit takes the old words.
      ent = 71'h15_DF0F_1234_ABCD_8001;
      load_entry(ent);
      @(negedge clock);
      word_wr = 3'h1;
      word_wdata = 32'hFFFF_0000;
      table_access_control_wr = 1'b1;
      entry_pointer = 6'h28;
      access_direction = 1'b1;
      @(negedge clock);
      word_wr = 3'h0;
      table_access_control_wr = 1'b0;
      check(71'(table_word0), 71'hFFFF_0000, "word beside commit");
      // Word write beside a read: the read wins.
      @(negedge clock);
      word_wr = 3'h2;
      word_wdata = 32'h0000_0000;
      table_access_control_wr = 1'b1;
      access_direction = 1'b0;
      @(negedge clock);
      word_wr = 3'h0;
      table_access_control_wr = 1'b0;
      check_words(ent, kinds[5]);
      $display("test overlapping writes done");
      // A reset in mid-run empties the table.
      do_reset();
      ctl(6'h28, 1'b0);
      check_words('0, LTE_K_FREE);
      $display("test mid-run reset done");
      wrap_up();
   end
endmodule
